// ===== ebtoc_pkg.sv
// Constants, register map and types for the eight-bit overflow timer
package ebtoc_pkg;

	localparam int unsigned PSC_W = 13;
	localparam int unsigned REG_W = 8;
	localparam int unsigned DAT_W = 32;
	localparam int unsigned ADR_W = 18;
	localparam int unsigned SEL_W = 4;
	localparam int unsigned IDX_W = 16;
	localparam int unsigned IDX_LO = 2;

	localparam logic [IDX_W-1:0] IDX_CTRL0 = 16'hffa0;
	localparam logic [IDX_W-1:0] IDX_CSR   = 16'hffa1;
	localparam logic [IDX_W-1:0] IDX_CNT   = 16'hffa4;
	localparam logic [IDX_W-1:0] IDX_CTRL1 = 16'hfff5;

	localparam logic [REG_W-1:0] CTRL0_RST = 8'h00;
	localparam logic [REG_W-1:0] CTRL1_RST = 8'h00;
	localparam logic [REG_W-1:0] CNT_RST   = 8'h00;
	localparam logic [3:0]       OS_RST    = 4'h0;
	localparam logic [REG_W-1:0] CNT_MAX   = 8'hff;
	localparam logic [PSC_W-1:0] PSC_RST   = 13'h0000;

	localparam int unsigned CTRL0_OVERFLOW_IRQ_ENABLE_BIT = 5;
	localparam int unsigned CTRL0_CKS_HI   = 2;
	localparam int unsigned CTRL0_CKS_LO   = 0;
	localparam int unsigned CSR_OVF_BIT    = 5;
	localparam int unsigned CSR_OS_HI      = 3;
	localparam int unsigned CSR_OS_LO      = 0;
	localparam int unsigned CTRL1_TVEG_HI  = 4;
	localparam int unsigned CTRL1_TVEG_LO  = 3;
	localparam int unsigned CTRL1_TRIGGER_GATE_ENABLE_BIT = 2;
	localparam int unsigned CTRL1_ICKS_BIT = 0;

	localparam logic [2:0] CKS_STOP     = 3'h0;
	localparam logic [2:0] CKS_INT_A    = 3'h1;
	localparam logic [2:0] CKS_INT_B    = 3'h2;
	localparam logic [2:0] CKS_INT_C    = 3'h3;
	localparam logic [2:0] CKS_EXT_RISE = 3'h4;
	localparam logic [2:0] CKS_EXT_FALL = 3'h5;
	localparam logic [2:0] CKS_EXT_BOTH = 3'h6;

	localparam logic [PSC_W-1:0] MASK_DIV4   = 13'h0003;
	localparam logic [PSC_W-1:0] MASK_DIV8   = 13'h0007;
	localparam logic [PSC_W-1:0] MASK_DIV16  = 13'h000f;
	localparam logic [PSC_W-1:0] MASK_DIV32  = 13'h001f;
	localparam logic [PSC_W-1:0] MASK_DIV64  = 13'h003f;
	localparam logic [PSC_W-1:0] MASK_DIV128 = 13'h007f;

	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	typedef enum logic {
		EBTOC_WAIT,
		EBTOC_RUN
	} ebtoc_run_t;

endpackage

// ===== ebtoc_timer.sv
// Eight-bit overflow timer with prescaler, trigger gate and Wishbone registers
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Thirteen-bit prescaler counts up by one on every system clock.
// - Eight-bit counter, readable and writable, advances on each selected count edge.
// - Count source is one of six prescaler taps or three external edge modes.
// - Select 0,1,1 counts on the falling edge of the divide-by-64 tap.
// - Extension bit joins the select bits; 1 with 0,1,1 picks divide-by-128.
// - Overflow interrupt enable bit 5 of control zero blocks or allows requests.
// - Status bit 5 reads 1 after an overflow, 0 otherwise.
// - Interrupt request rises on counter overflow when overflow interrupts are enabled.
// - Without clearing the counter wraps every 256 count edges.
// - Trigger edge field 00 makes the trigger pin ignored.
// - Trigger gate 1: trigger starts counting; compare clear would stop it.
// - Control zero holds clock select, clear selection and interrupt enables.
// - Status register holds the overflow flag and output selects; match flags read zero.
module ebtoc_timer (
	input  wire logic                        I_CLK_SYS,
	input  wire logic                        I_RST_N,
	input  wire logic                        I_WB_CYC,
	input  wire logic                        I_WB_STB,
	input  wire logic                        I_WB_WE,
	input  wire logic [ebtoc_pkg::ADR_W-1:0] I_WB_ADR,
	input  wire logic [ebtoc_pkg::SEL_W-1:0] I_WB_SEL,
	input  wire logic [ebtoc_pkg::DAT_W-1:0] I_WB_DAT,
	input  wire logic                        I_EXT_CLK,
	input  wire logic                        I_TRIGGER_PIN,
	output logic                             O_WB_ACK,
	output logic      [ebtoc_pkg::DAT_W-1:0] O_WB_DAT,
	output logic                             O_IRQ,
	output logic                             O_COMPARE_OUT
);
	import ebtoc_pkg::*;

	logic [PSC_W-1:0] psc_ff;
	logic [REG_W-1:0] ctrl0_ff;
	logic [REG_W-1:0] ctrl1_ff;
	logic [REG_W-1:0] cnt_ff;
	logic [3:0]       os_ff;
	logic             ovf_ff;
	logic             irq_ff;
	logic             ack_ff;
	logic [DAT_W-1:0] rdat_ff;
	logic             cmp_out_ff;
	ebtoc_run_t       run_ff;
	ebtoc_run_t       nxt_run;
	logic             ext_s1_ff;
	logic             ext_s2_ff;
	logic             ext_s3_ff;
	logic             trg_s1_ff;
	logic             trg_s2_ff;
	logic             trg_s3_ff;

	logic [IDX_W-1:0] bus_idx;
	logic             bus_req;
	logic             wr_hit;
	logic             wr_ctrl0;
	logic             wr_ctrl1;
	logic             wr_cnt;
	logic             wr_csr;
	logic [2:0]       cks;
	logic             icks;
	logic [1:0]       tveg;
	logic             trigger_gate_enable;
	logic             overflow_irq_enable;
	logic [PSC_W-1:0] tap_mask;
	logic             is_int;
	logic             tick_int;
	logic             tick_ext;
	logic             trig_evt;
	logic             gate_open;
	logic             count_en;
	logic             wrap;
	logic [REG_W-1:0] csr_view;
	logic [DAT_W-1:0] nxt_rdat;

	function automatic logic [IDX_W-1:0] idx_of(input logic [ADR_W-1:0] adr);
		idx_of = adr[IDX_LO +: IDX_W];
	endfunction

	// Tap bit k falls when the low k+1 prescaler bits are all ones
	function automatic logic [PSC_W-1:0] tap_of(input logic [2:0] sel, input logic ext);
		case (sel)
			CKS_INT_A: tap_of = ext ? MASK_DIV8 : MASK_DIV4;
			CKS_INT_B: tap_of = ext ? MASK_DIV32 : MASK_DIV16;
			CKS_INT_C: tap_of = ext ? MASK_DIV128 : MASK_DIV64;
			default:   tap_of = MASK_DIV4;
		endcase
	endfunction

	function automatic logic edge_hit(input logic [1:0] mode, input logic rise,
			input logic fall);
		case (mode)
			EDGE_RISE: edge_hit = rise;
			EDGE_FALL: edge_hit = fall;
			EDGE_BOTH: edge_hit = rise | fall;
			default:   edge_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [1:0] ext_mode(input logic [2:0] sel);
		case (sel)
			CKS_EXT_RISE: ext_mode = EDGE_RISE;
			CKS_EXT_FALL: ext_mode = EDGE_FALL;
			CKS_EXT_BOTH: ext_mode = EDGE_BOTH;
			default:      ext_mode = EDGE_OFF;
		endcase
	endfunction

	// Field views
	assign cks  = ctrl0_ff[CTRL0_CKS_HI:CTRL0_CKS_LO];
	assign overflow_irq_enable = ctrl0_ff[CTRL0_OVERFLOW_IRQ_ENABLE_BIT];
	assign icks = ctrl1_ff[CTRL1_ICKS_BIT];
	assign tveg = ctrl1_ff[CTRL1_TVEG_HI:CTRL1_TVEG_LO];
	assign trigger_gate_enable = ctrl1_ff[CTRL1_TRIGGER_GATE_ENABLE_BIT];

	// Bus decode; writes land on the edge where ack is seen high
	assign bus_idx  = idx_of(I_WB_ADR);
	assign bus_req  = I_WB_CYC & I_WB_STB;
	assign wr_hit   = bus_req & I_WB_WE & ack_ff & I_WB_SEL[0];
	assign wr_ctrl0 = wr_hit & (bus_idx == IDX_CTRL0);
	assign wr_ctrl1 = wr_hit & (bus_idx == IDX_CTRL1);
	assign wr_cnt   = wr_hit & (bus_idx == IDX_CNT);
	assign wr_csr   = wr_hit & (bus_idx == IDX_CSR);

	// Count edge selection
	assign is_int   = (cks == CKS_INT_A) | (cks == CKS_INT_B) | (cks == CKS_INT_C);
	assign tap_mask = tap_of(cks, icks);
	assign tick_int = is_int & ((psc_ff & tap_mask) == tap_mask);
	assign tick_ext = edge_hit(ext_mode(cks), ext_s2_ff & ~ext_s3_ff,
			~ext_s2_ff & ext_s3_ff);
	assign trig_evt = edge_hit(tveg, trg_s2_ff & ~trg_s3_ff, ~trg_s2_ff & trg_s3_ff);
	assign gate_open = ~trigger_gate_enable | (run_ff == EBTOC_RUN);
	assign count_en  = (tick_int | tick_ext) & gate_open;
	assign wrap      = count_en & ~wr_cnt & (cnt_ff == CNT_MAX);

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			psc_ff <= PSC_RST;
		end else begin
			psc_ff <= psc_ff + 1'b1;
		end
	end

	// Pins cross into the system clock; stage one feeds only stage two
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			ext_s3_ff <= 1'b0;
			trg_s1_ff <= 1'b0;
			trg_s2_ff <= 1'b0;
			trg_s3_ff <= 1'b0;
		end else begin
			ext_s1_ff <= I_EXT_CLK;
			ext_s2_ff <= ext_s1_ff;
			ext_s3_ff <= ext_s2_ff;
			trg_s1_ff <= I_TRIGGER_PIN;
			trg_s2_ff <= trg_s1_ff;
			trg_s3_ff <= trg_s2_ff;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl0_ff <= CTRL0_RST;
			ctrl1_ff <= CTRL1_RST;
		end else begin
			if (wr_ctrl0) begin
				ctrl0_ff <= I_WB_DAT[REG_W-1:0];
			end
			if (wr_ctrl1) begin
				ctrl1_ff <= I_WB_DAT[REG_W-1:0];
			end
		end
	end

	// Gate state: dropping the gate bit re-arms for the next trigger
	always_comb begin
		nxt_run = run_ff;
		case (run_ff)
			EBTOC_WAIT: begin
				if (trigger_gate_enable && trig_evt) begin
					nxt_run = EBTOC_RUN;
				end
			end
			EBTOC_RUN: begin
				if (!trigger_gate_enable) begin
					nxt_run = EBTOC_WAIT;
				end
			end
			default: nxt_run = EBTOC_WAIT;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			run_ff <= EBTOC_WAIT;
		end else begin
			run_ff <= nxt_run;
		end
	end

	// Software write beats a coincident count edge
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cnt_ff <= CNT_RST;
		end else if (wr_cnt) begin
			cnt_ff <= I_WB_DAT[REG_W-1:0];
		end else if (count_en) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// Writing 0 to the flag clears it; a wrap in the same cycle wins
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ovf_ff <= 1'b0;
			os_ff  <= OS_RST;
		end else begin
			if (wrap) begin
				ovf_ff <= 1'b1;
			end else if (wr_csr && !I_WB_DAT[CSR_OVF_BIT]) begin
				ovf_ff <= 1'b0;
			end
			if (wr_csr) begin
				os_ff <= I_WB_DAT[CSR_OS_HI:CSR_OS_LO];
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= ovf_ff & overflow_irq_enable;
		end
	end

	// No compare unit, so the output pin idles low whatever the selects say
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cmp_out_ff <= 1'b0;
		end else begin
			cmp_out_ff <= 1'b0;
		end
	end

	// Match flags read zero, reserved bit reads zero
	always_comb begin
		csr_view = '0;
		csr_view[CSR_OVF_BIT] = ovf_ff;
		csr_view[CSR_OS_HI:CSR_OS_LO] = os_ff;
	end

	always_comb begin
		nxt_rdat = '0;
		case (bus_idx)
			IDX_CTRL0: nxt_rdat = {{(DAT_W-REG_W){1'b0}}, ctrl0_ff};
			IDX_CTRL1: nxt_rdat = {{(DAT_W-REG_W){1'b0}}, ctrl1_ff};
			IDX_CNT:   nxt_rdat = {{(DAT_W-REG_W){1'b0}}, cnt_ff};
			IDX_CSR:   nxt_rdat = {{(DAT_W-REG_W){1'b0}}, csr_view};
			default:   nxt_rdat = '0;
		endcase
	end

	// One wait state; unmapped addresses still ack, reading zero
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
			if (bus_req && !ack_ff && !I_WB_WE) begin
				rdat_ff <= nxt_rdat;
			end
		end
	end

	assign O_WB_ACK      = ack_ff;
	assign O_WB_DAT      = rdat_ff;
	assign O_IRQ         = irq_ff;
	assign O_COMPARE_OUT = cmp_out_ff;

	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RST_N);

	sequence s_sel128;
		(cks == CKS_INT_C) && icks && ((psc_ff & MASK_DIV128) == MASK_DIV128);
	endsequence
	sequence s_plain_count;
		count_en && !wr_cnt;
	endsequence
	sequence s_bus_handshake;
		(bus_req && !ack_ff) ##1 ack_ff ##1 !ack_ff;
	endsequence

	// Prescaler sits at zero for the edge that ends reset, so skip that step
	AST_PSC_STEP: assert property (
		$past(I_RST_N) |-> psc_ff == PSC_W'($past(psc_ff) + 1'b1))
		else $error("prescaler did not advance by one");
	AST_DIV128_EDGE: assert property (
		s_sel128 and (!wr_cnt && gate_open) |=>
			((psc_ff & MASK_DIV128) == PSC_RST) && (cnt_ff == REG_W'($past(cnt_ff) + 1'b1)))
		else $error("divide-by-128 edge did not advance the counter");
	AST_COUNT_UP: assert property (
		s_plain_count |=> cnt_ff == REG_W'($past(cnt_ff) + 1'b1))
		else $error("counter missed a count edge");
	AST_COUNT_HOLD: assert property (
		!count_en && !wr_cnt |=> $stable(cnt_ff))
		else $error("counter moved without a count edge");
	AST_WRAP: assert property (
		s_plain_count and (cnt_ff == CNT_MAX) |=> (cnt_ff == CNT_RST) && ovf_ff)
		else $error("wrap did not reach zero with flag set");
	AST_OVF_STICKY: assert property (
		ovf_ff && !(wr_csr && !I_WB_DAT[CSR_OVF_BIT]) |=> ovf_ff)
		else $error("overflow flag dropped without a clear");
	AST_IRQ_FOLLOW: assert property (
		(ovf_ff && overflow_irq_enable) |=> O_IRQ ##1 (O_IRQ == $past(ovf_ff && overflow_irq_enable)))
		else $error("interrupt request does not follow flag and enable");
	AST_IRQ_BLOCKED: assert property (
		!overflow_irq_enable ##1 !overflow_irq_enable |-> !O_IRQ)
		else $error("interrupt raised while disabled");
	AST_TRIG_IGNORED: assert property (
		trigger_gate_enable && (tveg == EDGE_OFF) && (run_ff == EBTOC_WAIT) |=> run_ff == EBTOC_WAIT)
		else $error("trigger pin acted while ignored");
	AST_TRIG_START: assert property (
		trigger_gate_enable && trig_evt && (run_ff == EBTOC_WAIT) |=> gate_open || !trigger_gate_enable)
		else $error("trigger did not start counting");
	AST_GATE_HOLD: assert property (
		trigger_gate_enable && (run_ff == EBTOC_WAIT) && !wr_cnt |=> $stable(cnt_ff))
		else $error("counter moved before trigger");
	AST_BUS_ACK: assert property (
		bus_req && !ack_ff |-> s_bus_handshake or (##1 ack_ff ##1 (bus_req && !ack_ff)))
		else $error("bus ack not given one cycle after request");
endmodule

// ===== test_eight_bit_timer_overflow_counter.sv
// Self-checking bench for the eight-bit overflow timer
`timescale 1ns/1ps
module test_eight_bit_timer_overflow_counter;
	import ebtoc_pkg::*;

	typedef struct {logic [IDX_W-1:0] idx; logic [7:0] wd; logic [7:0] rd;} ebtoc_row_t;
	typedef struct {logic icks; logic [2:0] cks; int div;} ebtoc_div_t;

	logic              clk     = 1'b0;
	logic              rst_n   = 1'b0;
	logic              cyc     = 1'b0;
	logic              stb     = 1'b0;
	logic              we      = 1'b0;
	logic [ADR_W-1:0]  adr     = '0;
	logic [SEL_W-1:0]  sel     = 4'h1;
	logic [DAT_W-1:0]  wdat    = '0;
	logic              ext_clk = 1'b0;
	logic              trig    = 1'b0;
	logic              ack;
	logic [DAT_W-1:0]  rdat;
	logic              irq;
	logic              cmp_out;
	logic [31:0]       q;
	int                n_fail    = 0;
	int                tests_run = 0;
	int                cyc_n     = 0;

	// Stored bits read back; status flag bit ignores a written 1
	ebtoc_row_t rows [6] = '{
		'{IDX_CTRL0, 8'hd8, 8'hd8}, '{IDX_CTRL1, 8'he0, 8'he0},
		'{IDX_CNT, 8'ha5, 8'ha5}, '{IDX_CSR, 8'hff, 8'h0f},
		'{16'hffa2, 8'h55, 8'h00}, '{IDX_CSR, 8'h00, 8'h00}};
	ebtoc_div_t divs [6] = '{'{1'b0, 3'h1, 4}, '{1'b1, 3'h1, 8}, '{1'b0, 3'h2, 16},
		'{1'b1, 3'h2, 32}, '{1'b0, 3'h3, 64}, '{1'b1, 3'h3, 128}};

	ebtoc_timer ebtoc_timer_i (
		.I_CLK_SYS     (clk),
		.I_RST_N       (rst_n),
		.I_WB_CYC      (cyc),
		.I_WB_STB      (stb),
		.I_WB_WE       (we),
		.I_WB_ADR      (adr),
		.I_WB_SEL      (sel),
		.I_WB_DAT      (wdat),
		.I_EXT_CLK     (ext_clk),
		.I_TRIGGER_PIN (trig),
		.O_WB_ACK      (ack),
		.O_WB_DAT      (rdat),
		.O_IRQ         (irq),
		.O_COMPARE_OUT (cmp_out)
	);

	always #2.5 clk = ~clk;

	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
	end

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Ack and read data are taken at the same edge, then released
	task automatic wb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] d,
		input logic [3:0] s, output logic [31:0] r);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= {idx, 2'b00};
		wdat <= {24'h00_0000, d};
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (i == 20) begin
			n_fail++;
			wrap_up();
		end
	endtask

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
		logic [31:0] r;
		wb(1'b1, idx, d, 4'h1, r);
	endtask

	task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] r);
		wb(1'b0, idx, 8'h00, 4'h1, r);
	endtask

	task automatic wait_irq(input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk);
			if (irq === 1'b1) break;
		end
		if (i == lim) begin
			n_fail++;
			wrap_up();
		end
	endtask

	// Overflow spacing from a free-running prescaler must be exact
	task automatic period(input ebtoc_div_t r);
		int t0;
		logic [31:0] v;
		wr(IDX_CTRL0, 8'h00);
		wr(IDX_CSR, 8'h00);
		wr(IDX_CNT, 8'hff);
		wr(IDX_CTRL1, {7'h00, r.icks});
		wr(IDX_CTRL0, 8'h20 | {5'h00, r.cks});
		wait_irq(256 * r.div + 50);
		t0 = cyc_n;
		rd(IDX_CSR, v);
		check("overflow flag", v, 32'h0000_0020);
		wr(IDX_CSR, 8'h00);
		ticks(2);
		check("irq after clear", {31'h0, irq}, 32'h0000_0000);
		wait_irq(256 * r.div + 50);
		check("overflow period", 32'(cyc_n - t0), 32'(256 * r.div));
	endtask

	initial begin
		ticks(2);
		rst_n <= 1'b1;
		check("irq at reset", {31'h0, irq}, 32'h0000_0000);
		rd(IDX_CNT, q);
		check("count at reset", q, 32'h0000_0000);
		foreach (rows[k]) begin
			wr(rows[k].idx, rows[k].wd);
			rd(rows[k].idx, q);
			check("register readback", q, {24'h00_0000, rows[k].rd});
		end
		foreach (divs[k]) period(divs[k]);
		wr(IDX_CTRL0, 8'h00);
		wr(IDX_CTRL1, 8'h00);
		wr(IDX_CNT, 8'h33);
		wb(1'b1, IDX_CNT, 8'hcc, 4'he, q);
		rd(IDX_CNT, q);
		check("write without lane 0", q, 32'h0000_0033);
		for (int k = 0; k < 3; k++) begin
			wr(IDX_CNT, 8'h00);
			wr(IDX_CTRL0, 8'h04 + 8'(k));
			repeat (5) begin
				ext_clk <= 1'b1;
				ticks(4);
				ext_clk <= 1'b0;
				ticks(4);
			end
			ticks(4);
			wr(IDX_CTRL0, 8'h00);
			rd(IDX_CNT, q);
			check("external edges", q, (k == 2) ? 32'h0000_000a : 32'h0000_0005);
		end
		wr(IDX_CNT, 8'h00);
		wr(IDX_CTRL1, 8'h04);
		wr(IDX_CTRL0, 8'h01);
		trig <= 1'b1;
		ticks(8);
		trig <= 1'b0;
		ticks(40);
		rd(IDX_CNT, q);
		check("trigger ignored", q, 32'h0000_0000);
		wr(IDX_CTRL1, 8'h0c);
		ticks(40);
		rd(IDX_CNT, q);
		check("gate holds", q, 32'h0000_0000);
		trig <= 1'b1;
		ticks(40);
		rd(IDX_CNT, q);
		check("gate opened", {31'h0, q != 32'h0}, 32'h0000_0001);
		wr(IDX_CTRL1, 8'h00);
		wr(IDX_CSR, 8'h00);
		wr(IDX_CNT, 8'hff);
		wr(IDX_CTRL0, 8'h01);
		ticks(20);
		rd(IDX_CSR, q);
		check("flag while masked", q, 32'h0000_0020);
		check("irq masked", {31'h0, irq}, 32'h0000_0000);
		wr(IDX_CTRL0, 8'h21);
		ticks(2);
		check("irq unmasked", {31'h0, irq}, 32'h0000_0001);
		wr(IDX_CTRL0, 8'h01);
		ticks(2);
		check("irq masked again", {31'h0, irq}, 32'h0000_0000);
		check("compare pin idle", {31'h0, cmp_out}, 32'h0000_0000);
		rst_n <= 1'b0;
		ticks(2);
		rst_n <= 1'b1;
		rd(IDX_CTRL0, q);
		check("control after reset", q, 32'h0000_0000);
		wrap_up();
	end
endmodule
